/* rtl/dcpm_params.svh */
// Offsets, field positions, reset values and timing counts of the block
`ifndef DCPM_PARAMS_SVH
`define DCPM_PARAMS_SVH

// Register byte offsets
`define DCPM_OFS_GPO_CTRL   6'h00
`define DCPM_OFS_FLAG_RB    6'h04
`define DCPM_OFS_HOST_FEAT  6'h08
`define DCPM_OFS_PIN_DIR    6'h0c
`define DCPM_OFS_PM_CTRL    6'h10
`define DCPM_OFS_VID_DATA   6'h14
`define DCPM_OFS_VID_STAT   6'h18
`define DCPM_OFS_IDLE_CNT   6'h1c

// Output control field: activity pin level
`define DCPM_GPO_ACT_LVL    4
`define DCPM_GPO_ACT_AUX    5
// Host feature fields
`define DCPM_HF_HDIS_EN     4
`define DCPM_HF_CRUN_EN     5
// Pin direction fields (1 = output; for the refresh pin, 1 = status input)
`define DCPM_PD_REF_STAT    0
`define DCPM_PD_ACT_OUT     1
`define DCPM_PD_SUSP_OUT    2
`define DCPM_PD_STBY_OUT    3
// Power management control fields
`define DCPM_PM_SW_SUSP     0
`define DCPM_PM_STBY_REQ    1
`define DCPM_PM_FAST_REF    2
`define DCPM_PM_AUTO_STBY   3
// Flag readback fields
`define DCPM_FR_REF_PIN     0
`define DCPM_FR_STANDBY     1
`define DCPM_FR_SUSPEND     2
`define DCPM_FR_ACTIVITY    3
`define DCPM_FR_SELFTEST    4

// Reset values
`define DCPM_RST_GPO_CTRL   8'h00
`define DCPM_RST_HOST_FEAT  8'h00
`define DCPM_RST_PIN_DIR    8'h00
`define DCPM_RST_PM_CTRL    8'h00

// Timing
`define DCPM_CLK_HZ         200000000
`define DCPM_SLOW_REF_HZ    32768
`define DCPM_FAST_REF_HZ    14318180
// Fast reference edges per refresh tick, matching the slow rate
`define DCPM_FAST_DIV       (`DCPM_FAST_REF_HZ / `DCPM_SLOW_REF_HZ)
`define DCPM_IDLE_LIMIT     32'd200000000

`endif

/* rtl/dcpm_pkg.sv */
// Types shared by the power management and video port block
`default_nettype none
package dcpm_pkg;

  // One captured video port word
  typedef struct packed {
    logic       frame_sync;
    logic       line_sync;
    logic [7:0] chroma;
    logic [7:0] luma;
  } dcpm_pixel_t;

  // Bus slave handshake states
  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_ACK
  } dcpm_bus_state_t;

endpackage

`default_nettype wire

/* rtl/dcpm_sync.sv */
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
`default_nettype none

module dcpm_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule

`default_nettype wire

/* rtl/dcpm_top.sv */
// Power management, host control and video port pins of the controller
`timescale 1ns/10ps
`default_nettype none
`include "dcpm_params.svh"

module dcpm_top
  import dcpm_pkg::*;
#(
  parameter int          FAST_DIV   = `DCPM_FAST_DIV,
  parameter logic [31:0] IDLE_LIMIT = `DCPM_IDLE_LIMIT
) (
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        ARST_N_I,
  // Avalon-MM slave
  input  wire logic [5:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  output logic      [31:0] AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  // Power management pins
  input  wire logic        SUSPEND_PIN_I,
  output logic             SUSPEND_PIN_O,
  output logic             SUSPEND_PIN_OE_O,
  input  wire logic        ACTIVITY_PIN_I,
  output logic             ACTIVITY_PIN_O,
  output logic             ACTIVITY_PIN_OE_O,
  input  wire logic        STANDBY_FLAG_PIN_I,
  output logic             STANDBY_FLAG_PIN_O,
  output logic             STANDBY_FLAG_PIN_OE_O,
  input  wire logic        SLOW_REFRESH_REF_IN_I,
  input  wire logic        FAST_REF_I,
  output logic             REFRESH_TICK_O,
  output logic             SUSPEND_STATE_O,
  // Host control pins
  input  wire logic        CLKRUN_N_I,
  output logic             CLKRUN_N_O,
  output logic             CLKRUN_N_OE_O,
  input  wire logic        HOST_ACCESS_DISABLE_I,
  input  wire logic        MEM_SELFTEST_N_I,
  output logic             MEM_TEST_MODE_O,
  // Video port
  input  wire logic        VID_PCLK_I,
  input  wire logic [7:0]  CHROMA_IN_I,
  input  wire logic [7:0]  LUMA_IN_I,
  input  wire logic        LINE_SYNC_IN_I,
  input  wire logic        FRAME_SYNC_IN_I,
  output dcpm_pixel_t      VID_PIXEL_O,
  output logic             VID_PIXEL_VALID_O
);

  // Synchronised pin levels
  logic        act_s;
  logic        susp_s;
  logic        stby_s;
  logic        slow_s;
  logic        fast_s;
  logic        crun_s;
  logic        hdis_s;
  logic        mem_selftest_n_s;
  logic        pclk_s;
  dcpm_pixel_t pix_s;

  // Registers
  logic [7:0]      gpo_control_reg_q;
  logic [7:0]      host_feature_reg_q;
  logic [7:0]      pin_direction_reg_q;
  logic [7:0]      pm_control_reg_q;
  logic [31:0]     idle_cnt_q;
  logic            idle_expired_q;
  dcpm_pixel_t     vid_word_q;
  logic            vid_valid_q;
  logic [15:0]     frame_cnt_q;
  logic            slow_prev_q;
  logic            fast_prev_q;
  logic            pclk_prev_q;
  logic            frame_prev_q;
  logic [15:0]     fast_div_q;
  dcpm_bus_state_t bus_state_q;
  dcpm_bus_state_t bus_state_d;

  // Derived conditions
  logic hw_suspend;
  logic suspend_on;
  logic standby_on;
  logic host_block;
  logic bus_req;
  logic bus_commit;
  logic wr_en;
  logic rd_clr;
  logic pclk_rise;
  logic work_pending;

  // Control pins, each through two flip-flops
  dcpm_sync #(
    .W (9)
  ) u_sync_ctl (
    .clk_i    (CLK_I),
    .arst_n_i (ARST_N_I),
    .d_i      ({ACTIVITY_PIN_I, SUSPEND_PIN_I, STANDBY_FLAG_PIN_I,
                SLOW_REFRESH_REF_IN_I, FAST_REF_I, CLKRUN_N_I,
                HOST_ACCESS_DISABLE_I, MEM_SELFTEST_N_I, VID_PCLK_I}),
    .q_o      ({act_s, susp_s, stby_s, slow_s, fast_s, crun_s,
                hdis_s, mem_selftest_n_s, pclk_s})
  );

  // Video data crosses alongside its clock, so it is stable at the rise
  dcpm_sync #(
    .W ($bits(dcpm_pixel_t))
  ) u_sync_vid (
    .clk_i    (CLK_I),
    .arst_n_i (ARST_N_I),
    .d_i      ({FRAME_SYNC_IN_I, LINE_SYNC_IN_I, CHROMA_IN_I, LUMA_IN_I}),
    .q_o      (pix_s)
  );

  // Register address match on the word index
  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    hit = (a[5:2] == ofs[5:2]);
  endfunction

  // Power state
  assign hw_suspend = !pin_direction_reg_q[`DCPM_PD_SUSP_OUT] && susp_s;
  assign suspend_on = hw_suspend || pm_control_reg_q[`DCPM_PM_SW_SUSP];
  assign standby_on = pm_control_reg_q[`DCPM_PM_STBY_REQ] || idle_expired_q;

  // Host accesses are answered but have no effect while blocked
  assign host_block = (host_feature_reg_q[`DCPM_HF_HDIS_EN] && hdis_s)
                      || hw_suspend;
  assign bus_req    = AVS_READ_I || AVS_WRITE_I;
  assign bus_commit = (bus_state_q == BUS_ACK) && bus_req;
  assign wr_en      = bus_commit && AVS_WRITE_I && AVS_BYTEENABLE_I[0]
                      && !host_block;
  assign rd_clr     = bus_commit && AVS_READ_I && !host_block
                      && hit(AVS_ADDRESS_I, `DCPM_OFS_VID_DATA);

  // Bus handshake: one wait cycle, then the answer
  always_comb begin
    bus_state_d = bus_state_q;
    case (bus_state_q)
      BUS_IDLE: begin
        if (bus_req) begin
          bus_state_d = BUS_ACK;
        end
      end
      BUS_ACK: bus_state_d = BUS_IDLE;
      default: bus_state_d = BUS_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      bus_state_q       <= BUS_IDLE;
      AVS_WAITREQUEST_O <= 1'b1;
    end else begin
      bus_state_q       <= bus_state_d;
      AVS_WAITREQUEST_O <= !(bus_state_d == BUS_ACK);
    end
  end

  // Read data, loaded on the same edge that waitrequest drops
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      AVS_READDATA_O <= 32'h0000_0000;
    end else if (bus_state_q == BUS_IDLE && AVS_READ_I) begin
      AVS_READDATA_O <= 32'h0000_0000;
      if (!host_block) begin
        if (hit(AVS_ADDRESS_I, `DCPM_OFS_GPO_CTRL)) begin
          AVS_READDATA_O[7:0] <= gpo_control_reg_q;
        end
        if (hit(AVS_ADDRESS_I, `DCPM_OFS_FLAG_RB)) begin
          AVS_READDATA_O[`DCPM_FR_REF_PIN]  <= slow_s;
          AVS_READDATA_O[`DCPM_FR_STANDBY]  <= standby_on;
          AVS_READDATA_O[`DCPM_FR_SUSPEND]  <= suspend_on;
          AVS_READDATA_O[`DCPM_FR_ACTIVITY] <= act_s;
          AVS_READDATA_O[`DCPM_FR_SELFTEST] <= !mem_selftest_n_s;
        end
        if (hit(AVS_ADDRESS_I, `DCPM_OFS_HOST_FEAT)) begin
          AVS_READDATA_O[7:0] <= host_feature_reg_q;
        end
        if (hit(AVS_ADDRESS_I, `DCPM_OFS_PIN_DIR)) begin
          AVS_READDATA_O[7:0] <= pin_direction_reg_q;
        end
        if (hit(AVS_ADDRESS_I, `DCPM_OFS_PM_CTRL)) begin
          AVS_READDATA_O[7:0] <= pm_control_reg_q;
        end
        if (hit(AVS_ADDRESS_I, `DCPM_OFS_VID_DATA)) begin
          AVS_READDATA_O[17:0] <= vid_word_q;
        end
        if (hit(AVS_ADDRESS_I, `DCPM_OFS_VID_STAT)) begin
          AVS_READDATA_O[0]     <= vid_valid_q;
          AVS_READDATA_O[31:16] <= frame_cnt_q;
        end
        if (hit(AVS_ADDRESS_I, `DCPM_OFS_IDLE_CNT)) begin
          AVS_READDATA_O <= idle_cnt_q;
        end
      end
    end
  end

  // Software writable registers, low byte lane only
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      gpo_control_reg_q   <= `DCPM_RST_GPO_CTRL;
      host_feature_reg_q  <= `DCPM_RST_HOST_FEAT;
      pin_direction_reg_q <= `DCPM_RST_PIN_DIR;
      pm_control_reg_q    <= `DCPM_RST_PM_CTRL;
    end else if (wr_en) begin
      if (hit(AVS_ADDRESS_I, `DCPM_OFS_GPO_CTRL)) begin
        gpo_control_reg_q <= AVS_WRITEDATA_I[7:0];
      end
      if (hit(AVS_ADDRESS_I, `DCPM_OFS_HOST_FEAT)) begin
        host_feature_reg_q <= AVS_WRITEDATA_I[7:0];
      end
      if (hit(AVS_ADDRESS_I, `DCPM_OFS_PIN_DIR)) begin
        pin_direction_reg_q <= AVS_WRITEDATA_I[7:0];
      end
      if (hit(AVS_ADDRESS_I, `DCPM_OFS_PM_CTRL)) begin
        pm_control_reg_q <= AVS_WRITEDATA_I[7:0];
      end
    end
  end

  // Idle timer; activity restarts it, hardware suspend masks the activity input
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      idle_cnt_q     <= 32'h0000_0000;
      idle_expired_q <= 1'b0;
    end else if (!pin_direction_reg_q[`DCPM_PD_ACT_OUT] && act_s
                 && !hw_suspend) begin
      idle_cnt_q     <= 32'h0000_0000;
      idle_expired_q <= 1'b0;
    end else if (idle_cnt_q >= IDLE_LIMIT) begin
      idle_expired_q <= pm_control_reg_q[`DCPM_PM_AUTO_STBY];
    end else begin
      idle_cnt_q     <= idle_cnt_q + 32'h0000_0001;
      idle_expired_q <= 1'b0;
    end
  end

  // Refresh ticks in standby and suspend from the selected reference
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      slow_prev_q    <= 1'b0;
      fast_prev_q    <= 1'b0;
      fast_div_q     <= 16'h0000;
      REFRESH_TICK_O <= 1'b0;
    end else begin
      slow_prev_q    <= slow_s;
      fast_prev_q    <= fast_s;
      REFRESH_TICK_O <= 1'b0;
      if (pm_control_reg_q[`DCPM_PM_FAST_REF]) begin
        if (fast_s && !fast_prev_q) begin
          if (fast_div_q >= 16'(FAST_DIV - 1)) begin
            fast_div_q     <= 16'h0000;
            REFRESH_TICK_O <= standby_on || suspend_on;
          end else begin
            fast_div_q <= fast_div_q + 16'h0001;
          end
        end
      end else if (!pin_direction_reg_q[`DCPM_PD_REF_STAT]) begin
        // A pin used as status input gives no refresh timing
        REFRESH_TICK_O <= slow_s && !slow_prev_q
                          && (standby_on || suspend_on);
      end
    end
  end

  // Power management pins
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      SUSPEND_PIN_O         <= 1'b0;
      SUSPEND_PIN_OE_O      <= 1'b0;
      ACTIVITY_PIN_O        <= 1'b0;
      ACTIVITY_PIN_OE_O     <= 1'b0;
      STANDBY_FLAG_PIN_O    <= 1'b0;
      STANDBY_FLAG_PIN_OE_O <= 1'b0;
      SUSPEND_STATE_O       <= 1'b0;
    end else begin
      SUSPEND_PIN_OE_O      <= pin_direction_reg_q[`DCPM_PD_SUSP_OUT];
      SUSPEND_PIN_O         <= pm_control_reg_q[`DCPM_PM_SW_SUSP];
      ACTIVITY_PIN_OE_O     <= pin_direction_reg_q[`DCPM_PD_ACT_OUT];
      ACTIVITY_PIN_O        <= gpo_control_reg_q[`DCPM_GPO_ACT_LVL]
                               ^ gpo_control_reg_q[`DCPM_GPO_ACT_AUX];
      STANDBY_FLAG_PIN_OE_O <= pin_direction_reg_q[`DCPM_PD_STBY_OUT];
      STANDBY_FLAG_PIN_O    <= standby_on;
      SUSPEND_STATE_O       <= suspend_on;
    end
  end

  // Clock-run: open drain, only ever pulls low
  assign work_pending = vid_valid_q || bus_req;

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      CLKRUN_N_O    <= 1'b0;
      CLKRUN_N_OE_O <= 1'b0;
    end else begin
      CLKRUN_N_O    <= 1'b0;
      CLKRUN_N_OE_O <= host_feature_reg_q[`DCPM_HF_CRUN_EN]
                       && crun_s && work_pending;
    end
  end

  // Self-test strap level, active low at the pin
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      MEM_TEST_MODE_O <= 1'b0;
    end else begin
      MEM_TEST_MODE_O <= !mem_selftest_n_s;
    end
  end

  // Pixel clock rise found in the system clock domain
  assign pclk_rise = pclk_s && !pclk_prev_q;

  // Video capture during display time; suspend disables the port
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pclk_prev_q       <= 1'b0;
      frame_prev_q      <= 1'b0;
      vid_word_q        <= '0;
      vid_valid_q       <= 1'b0;
      frame_cnt_q       <= 16'h0000;
      VID_PIXEL_O       <= '0;
      VID_PIXEL_VALID_O <= 1'b0;
    end else begin
      pclk_prev_q       <= pclk_s;
      VID_PIXEL_VALID_O <= 1'b0;
      if (pclk_rise && !suspend_on) begin
        frame_prev_q <= pix_s.frame_sync;
        if (pix_s.frame_sync && !frame_prev_q) begin
          frame_cnt_q <= frame_cnt_q + 16'h0001;
        end
        if (pix_s.line_sync) begin
          vid_word_q        <= pix_s;
          VID_PIXEL_O       <= pix_s;
          VID_PIXEL_VALID_O <= 1'b1;
        end
      end
      // A new word wins over a read that clears the flag
      if (pclk_rise && !suspend_on && pix_s.line_sync) begin
        vid_valid_q <= 1'b1;
      end else if (rd_clr) begin
        vid_valid_q <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

/* tb/dcpm_sva.sv */
// Assertion checker for the power management and video port block
`timescale 1ns/10ps
`default_nettype none
module dcpm_sva
  import dcpm_pkg::*;
#(
  parameter int          FAST_DIV   = 4,
  parameter logic [31:0] IDLE_LIMIT = 32'd100
) (
  // Clock, reset and bus handshake
  input wire logic        CLK_I,
  input wire logic        ARST_N_I,
  input wire logic        AVS_READ_I,
  input wire logic        AVS_WRITE_I,
  input wire logic        AVS_WAITREQUEST_O,
  // Power management and host pins
  input wire logic        SUSPEND_PIN_I,
  input wire logic        SUSPEND_PIN_OE_O,
  input wire logic        SUSPEND_STATE_O,
  input wire logic        STANDBY_FLAG_PIN_O,
  input wire logic        REFRESH_TICK_O,
  input wire logic        CLKRUN_N_I,
  input wire logic        CLKRUN_N_O,
  input wire logic        CLKRUN_N_OE_O,
  input wire logic        MEM_SELFTEST_N_I,
  input wire logic        MEM_TEST_MODE_O,
  // Video port
  input wire logic        VID_PCLK_I,
  input wire dcpm_pixel_t VID_PIXEL_O,
  input wire logic        VID_PIXEL_VALID_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);
  // Bus handshake steps, kept even while accesses are refused
  sequence bus_req_s;
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O;
  endsequence
  sequence bus_ack_s;
    !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O;
  endsequence
  bus_one_wait_a: assert property (bus_req_s |=> bus_ack_s)
    else $error("bus answer is not one wait cycle");
  clkrun_low_a: assert property (CLKRUN_N_OE_O |-> !CLKRUN_N_O)
    else $error("clock run driven high");
  clkrun_cause_a: assert property (
    $rose(CLKRUN_N_OE_O) |-> $past(CLKRUN_N_I, 3))
    else $error("clock run pulled without seeing it high");
  hw_suspend_a: assert property (
    (!SUSPEND_PIN_OE_O && SUSPEND_PIN_I) [*5] |-> SUSPEND_STATE_O)
    else $error("suspend input ignored");
  test_on_a: assert property ((!MEM_SELFTEST_N_I) [*5] |-> MEM_TEST_MODE_O)
    else $error("memory test mode missing");
  test_off_a: assert property (MEM_SELFTEST_N_I [*5] |-> !MEM_TEST_MODE_O)
    else $error("memory test mode without strap");
  pix_pulse_a: assert property (VID_PIXEL_VALID_O |=> !VID_PIXEL_VALID_O)
    else $error("pixel valid longer than one cycle");
  pix_line_a: assert property (VID_PIXEL_VALID_O |-> VID_PIXEL_O.line_sync)
    else $error("pixel captured outside a line");
  pix_edge_a: assert property (
    VID_PIXEL_VALID_O |-> $past(VID_PCLK_I, 3) && !$past(VID_PCLK_I, 4))
    else $error("pixel not taken after a rising edge");
  tick_state_a: assert property (
    REFRESH_TICK_O |-> SUSPEND_STATE_O || STANDBY_FLAG_PIN_O)
    else $error("refresh tick while awake");
endmodule
bind dcpm_top dcpm_sva #(.FAST_DIV(FAST_DIV), .IDLE_LIMIT(IDLE_LIMIT)) chk_u (
  .CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .AVS_READ_I(AVS_READ_I),
  .AVS_WRITE_I(AVS_WRITE_I), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
  .SUSPEND_PIN_I(SUSPEND_PIN_I), .SUSPEND_PIN_OE_O(SUSPEND_PIN_OE_O),
  .SUSPEND_STATE_O(SUSPEND_STATE_O), .STANDBY_FLAG_PIN_O(STANDBY_FLAG_PIN_O),
  .REFRESH_TICK_O(REFRESH_TICK_O), .CLKRUN_N_I(CLKRUN_N_I),
  .CLKRUN_N_O(CLKRUN_N_O), .CLKRUN_N_OE_O(CLKRUN_N_OE_O),
  .MEM_SELFTEST_N_I(MEM_SELFTEST_N_I), .MEM_TEST_MODE_O(MEM_TEST_MODE_O),
  .VID_PCLK_I(VID_PCLK_I), .VID_PIXEL_O(VID_PIXEL_O),
  .VID_PIXEL_VALID_O(VID_PIXEL_VALID_O));
`default_nettype wire

/* tb/dcpm_vid_src.sv */
// Video source model driving one short frame per request
`timescale 1ns/10ps
`default_nettype none
module dcpm_vid_src (
  // Frame request
  input  wire logic       go_i,
  // Video port toward the block
  output logic            pclk_o,
  output logic      [7:0] chroma_o,
  output logic      [7:0] luma_o,
  output logic            line_o,
  output logic            frame_o,
  output logic            busy_o
);
  // Idle levels; pixel clock stands still between frames
  initial begin
    pclk_o = 1'b0;
    chroma_o = 8'h00;
    luma_o = 8'hff;
    line_o = 1'b0;
    frame_o = 1'b0;
    busy_o = 1'b0;
  end
  // Frame pulse on the first of two blank beats, four active pixels, two blank
  always begin : frame_gen
    int i;
    @(posedge go_i);
    busy_o = 1'b1;
    for (i = 0; i < 8; i++) begin
      frame_o = (i == 0);
      line_o = (i >= 2) && (i < 6);
      chroma_o = 8'h10 + 8'(i);
      luma_o = 8'ha0 + 8'(i);
      #62.5 pclk_o = 1'b1;
      #62.5 pclk_o = 1'b0;
    end
    // Released lines show the inverse so stale data cannot match
    chroma_o = ~chroma_o;
    luma_o = ~luma_o;
    line_o = 1'b0;
    frame_o = 1'b0;
    busy_o = 1'b0;
  end
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking testbench of the power management and video port block
`timescale 1ns/10ps
`default_nettype none
`include "dcpm_params.svh"
module tb
  import dcpm_pkg::*;
;
  localparam int FDIV = 4;
  logic        clk, arst_n, rd, wr, wrq, sp_o, sp_oe, sp_drv, ac_o, ac_oe;
  logic        ac_drv, sb_o, sb_oe, slow, fast, tick, susp, cr_o, cr_oe;
  logic        host_low, had, st_n, mt, pclk, ls, fs, pv, vgo, vbusy;
  logic [5:0]  adr;
  logic [3:0]  be;
  logic [7:0]  chroma, luma;
  logic [31:0] wdat, rdat, q;
  dcpm_pixel_t pix;
  dcpm_pixel_t cap[$];
  int          miscompares, n_compared, ticks, oe_cnt;
  // Open-drain clock run wire with its pull-up
  wire cr_w = !(cr_oe || host_low);
  dcpm_top #(.FAST_DIV(FDIV), .IDLE_LIMIT(32'd100)) dut_u (
    .CLK_I(clk), .ARST_N_I(arst_n), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(be), .AVS_WRITEDATA_I(wdat),
    .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wrq),
    .SUSPEND_PIN_I(sp_oe ? sp_o : sp_drv), .SUSPEND_PIN_O(sp_o),
    .SUSPEND_PIN_OE_O(sp_oe), .ACTIVITY_PIN_I(ac_oe ? ac_o : ac_drv),
    .ACTIVITY_PIN_O(ac_o), .ACTIVITY_PIN_OE_O(ac_oe),
    .STANDBY_FLAG_PIN_I(sb_oe & sb_o), .STANDBY_FLAG_PIN_O(sb_o),
    .STANDBY_FLAG_PIN_OE_O(sb_oe), .SLOW_REFRESH_REF_IN_I(slow),
    .FAST_REF_I(fast), .REFRESH_TICK_O(tick), .SUSPEND_STATE_O(susp),
    .CLKRUN_N_I(cr_w), .CLKRUN_N_O(cr_o), .CLKRUN_N_OE_O(cr_oe),
    .HOST_ACCESS_DISABLE_I(had), .MEM_SELFTEST_N_I(st_n),
    .MEM_TEST_MODE_O(mt), .VID_PCLK_I(pclk), .CHROMA_IN_I(chroma),
    .LUMA_IN_I(luma), .LINE_SYNC_IN_I(ls), .FRAME_SYNC_IN_I(fs),
    .VID_PIXEL_O(pix), .VID_PIXEL_VALID_O(pv));
  dcpm_vid_src vid_u (.go_i(vgo), .pclk_o(pclk), .chroma_o(chroma),
    .luma_o(luma), .line_o(ls), .frame_o(fs), .busy_o(vbusy));
  always #2.5 clk = ~clk;
  // Monitors: refresh ticks, clock run drive cycles, captured words
  always @(posedge clk) begin
    if (tick === 1'b1) ticks <= ticks + 1;
    if (cr_oe === 1'b1) oe_cnt <= oe_cnt + 1;
    if (pv === 1'b1) cap.push_back(pix);
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One Avalon transfer held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    rd <= !w;
    wr <= w;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wrq !== 1'b0 && n < 64);
    if (n >= 64) miscompares++;
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wr_r(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd_c(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic ref_pulses(input logic f, input int n);
    repeat (n) begin
      if (f) fast <= 1'b1;
      else slow <= 1'b1;
      cyc(6);
      if (f) fast <= 1'b0;
      else slow <= 1'b0;
      cyc(6);
    end
    cyc(8);
  endtask
  // Reset values, unmapped word, byte enable off
  task automatic t_regs;
    rd_c(`DCPM_OFS_GPO_CTRL, 32'h0);
    rd_c(`DCPM_OFS_HOST_FEAT, 32'h0);
    rd_c(`DCPM_OFS_PIN_DIR, 32'h0);
    rd_c(`DCPM_OFS_PM_CTRL, 32'h0);
    wr_r(6'h20, 32'h30);
    rd_c(6'h20, 32'h0);
    be <= 4'h0;
    wr_r(`DCPM_OFS_GPO_CTRL, 32'h30);
    be <= 4'hf;
    rd_c(`DCPM_OFS_GPO_CTRL, 32'h0);
  endtask
  // Activity pin as output follows both control bits
  task automatic t_pins;
    int i;
    wr_r(`DCPM_OFS_PIN_DIR, 32'h0a);
    for (i = 0; i < 4; i++) begin
      wr_r(`DCPM_OFS_GPO_CTRL, i << 4);
      cyc(3);
      chk(ac_o, i[0] ^ i[1]);
    end
    chk({sb_oe, ac_oe, sp_oe, sb_o}, 4'hc);
    wr_r(`DCPM_OFS_PM_CTRL, 32'h02);
    cyc(3);
    chk(sb_o, 1'b1);
    wr_r(`DCPM_OFS_PM_CTRL, 32'h00);
  endtask
  // Software suspend, then slow and fast refresh sources
  task automatic t_susp;
    wr_r(`DCPM_OFS_PIN_DIR, 32'h04);
    wr_r(`DCPM_OFS_PM_CTRL, 32'h01);
    cyc(3);
    chk({sp_oe, sp_o, susp}, 3'b111);
    rd_c(`DCPM_OFS_FLAG_RB, 32'h04);
    ticks = 0;
    ref_pulses(1'b0, 5);
    chk(ticks, 5);
    wr_r(`DCPM_OFS_PM_CTRL, 32'h05);
    ticks = 0;
    ref_pulses(1'b1, 16);
    chk(ticks, 16 / FDIV);
    wr_r(`DCPM_OFS_PM_CTRL, 32'h00);
    ticks = 0;
    ref_pulses(1'b0, 3);
    chk({ticks[3:0], sp_o, susp}, 6'h0);
  endtask
  // Refresh pin as status input, self-test strap
  task automatic t_status;
    wr_r(`DCPM_OFS_PIN_DIR, 32'h01);
    slow <= 1'b1;
    st_n <= 1'b0;
    cyc(8);
    rd_c(`DCPM_OFS_FLAG_RB, 32'h11);
    chk(mt, 1'b1);
    slow <= 1'b0;
    st_n <= 1'b1;
    cyc(8);
    rd_c(`DCPM_OFS_FLAG_RB, 32'h00);
    chk(mt, 1'b0);
  endtask
  // One frame captured, then clock run with and without an unread word
  task automatic t_video;
    int i;
    oe_cnt = 0;
    vgo <= 1'b1;
    cyc(2);
    vgo <= 1'b0;
    for (i = 0; i < 400 && vbusy !== 1'b0; i++) cyc(1);
    cyc(8);
    chk(cap.size(), 4);
    for (i = 0; i < 4; i++) begin
      chk(cap[i], {2'b01, 8'h12 + i[7:0], 8'ha2 + i[7:0]});
    end
    bus(1'b0, `DCPM_OFS_VID_STAT, 32'h0);
    chk(q, 32'h0001_0001);
    cyc(20);
    chk(oe_cnt, 0);
    host_low <= 1'b1;
    wr_r(`DCPM_OFS_HOST_FEAT, 32'h20);
    oe_cnt = 0;
    cyc(20);
    chk(oe_cnt, 0);
    host_low <= 1'b0;
    cyc(20);
    chk(oe_cnt > 0, 1'b1);
    rd_c(`DCPM_OFS_VID_DATA, 32'h0001_15a5);
    cyc(12);
    oe_cnt = 0;
    cyc(20);
    chk(oe_cnt, 0);
    bus(1'b0, `DCPM_OFS_VID_STAT, 32'h0);
    chk(q, 32'h0001_0000);
    wr_r(`DCPM_OFS_HOST_FEAT, 32'h00);
  endtask
  // Host access disable with and without its enable, hardware suspend
  task automatic t_refuse;
    had <= 1'b1;
    wr_r(`DCPM_OFS_GPO_CTRL, 32'h20);
    rd_c(`DCPM_OFS_GPO_CTRL, 32'h20);
    had <= 1'b0;
    wr_r(`DCPM_OFS_HOST_FEAT, 32'h10);
    had <= 1'b1;
    cyc(4);
    wr_r(`DCPM_OFS_GPO_CTRL, 32'h30);
    rd_c(`DCPM_OFS_GPO_CTRL, 32'h00);
    had <= 1'b0;
    cyc(4);
    rd_c(`DCPM_OFS_GPO_CTRL, 32'h20);
    wr_r(`DCPM_OFS_HOST_FEAT, 32'h00);
    sp_drv <= 1'b1;
    cyc(6);
    chk(susp, 1'b1);
    wr_r(`DCPM_OFS_GPO_CTRL, 32'h10);
    sp_drv <= 1'b0;
    cyc(6);
    chk(susp, 1'b0);
    rd_c(`DCPM_OFS_GPO_CTRL, 32'h20);
  endtask
  // Activity keeps the idle timer from reaching standby
  task automatic t_idle;
    wr_r(`DCPM_OFS_PIN_DIR, 32'h08);
    wr_r(`DCPM_OFS_PM_CTRL, 32'h08);
    repeat (5) begin
      ac_drv <= 1'b1;
      cyc(4);
      ac_drv <= 1'b0;
      cyc(36);
    end
    chk(sb_o, 1'b0);
    cyc(150);
    chk(sb_o, 1'b1);
    rd_c(`DCPM_OFS_FLAG_RB, 32'h02);
    rd_c(`DCPM_OFS_IDLE_CNT, 32'h0000_0064);
    ticks = 0;
    ref_pulses(1'b0, 2);
    chk(ticks, 2);
  endtask
  task automatic test_done;
    if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog well beyond the expected run of little more than a thousand cycles
  initial begin
    #100000;
    miscompares++;
    test_done();
  end
  initial begin
    {clk, arst_n, rd, wr, sp_drv, ac_drv, slow, fast, host_low, had} = '0;
    {st_n, vgo, adr, be, wdat} = {2'b10, 6'h0, 4'hf, 32'h0};
    {miscompares, n_compared, ticks, oe_cnt} = '0;
    cyc(12);
    chk(wrq, 1'b1);
    arst_n <= 1'b1;
    t_regs();
    t_pins();
    t_susp();
    t_status();
    t_video();
    t_refuse();
    t_idle();
    test_done();
  end
endmodule
`default_nettype wire
